/* File: rtl/core_sfr_bank_low_pkg.sv */
// constants, field layouts and carrier types of the low special-function register bank
package core_sfr_bank_low_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int PC_HIGH_W = 3;
   localparam int DADDR_W = 7;
   localparam int BANK_W = 2;
   localparam int MEM_ADDR_W = BANK_W + DADDR_W;
   localparam int PORT_C_W = 2;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [DADDR_W-1:0] ADDR_INDIRECT_ACCESS_PORT = 7'h00;
   localparam logic [DADDR_W-1:0] ADDR_TIMER0_COUNT = 7'h01;
   localparam logic [DADDR_W-1:0] ADDR_PROGRAM_COUNTER_LOW = 7'h02;
   localparam logic [DADDR_W-1:0] ADDR_STATUS_FLAGS = 7'h03;
   localparam logic [DADDR_W-1:0] ADDR_INDIRECT_POINTER = 7'h04;
   localparam logic [DADDR_W-1:0] ADDR_PORT_A_DATA = 7'h05;
   localparam logic [DADDR_W-1:0] ADDR_PORT_B_DATA = 7'h06;
   localparam logic [DADDR_W-1:0] ADDR_PORT_C_DATA = 7'h07;
   localparam logic [DADDR_W-1:0] SFR_SPACE_LAST = 7'h1f;
   localparam logic [DADDR_W-1:0] SFR_BANK_LOW_LAST = 7'h07;

   // ---------------------------------------------------------------
   // status field positions
   // ---------------------------------------------------------------
   localparam int ST_CARRY = 0;
   localparam int ST_HALF_CARRY = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_POWER_DOWN = 3;
   localparam int ST_TIMEOUT = 4;
   localparam int ST_SPARE = 5;
   localparam int ST_BANK_LO = 6;
   localparam int ST_BANK_HI = 7;
   localparam int PTR_SPARE = 7;

   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
   localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
   localparam logic [DATA_W-1:0] TIMER0_RESET = 8'h00;
   localparam logic [DATA_W-1:0] PORT_LATCH_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;

   // ---------------------------------------------------------------
   // carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic c_we;
      logic dc_we;
      logic z_we;
      logic sub;
      logic carry;
      logic half_carry;
      logic [DATA_W-1:0] result;
   } alu_flags_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [MEM_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } mem_req_s;

endpackage : core_sfr_bank_low_pkg

/* File: rtl/core_sfr_bank_low.sv */
// low special-function register bank: indirect port, timer0, pc low, status, pointer, port data
`timescale 1ns/1ps

module core_sfr_bank_low
   import core_sfr_bank_low_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire sfr_req_s i_sfr_req,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_rvalid,
   output mem_req_s o_mem_req,
   input wire logic [DATA_W-1:0] i_mem_rdata,
   input wire logic i_inst_tick,
   input wire logic i_timer0_ext_clock_pin,
   input wire logic i_lfosc_tick,
   input wire logic i_timer0_mode_setting,
   input wire logic i_cfg_timer0_low_osc,
   input wire logic i_instr_done,
   input wire logic i_long_jump_instr,
   input wire logic i_long_call_instr,
   input wire logic [PC_W-1:0] i_instr_target,
   input wire logic [PC_HIGH_W-1:0] i_pc_high_buffer,
   output logic [PC_W-1:0] o_pc,
   output logic o_stack_push,
   output logic [PC_W-1:0] o_stack_data,
   input wire alu_flags_s i_alu_flags,
   input wire logic i_clrwdt_instr,
   input wire logic i_sleep_instr,
   input wire logic i_wdt_timeout,
   output logic [DATA_W-1:0] o_status_flags,
   output logic [BANK_W-1:0] o_bank_select,
   output logic [DATA_W-1:0] o_indirect_pointer,
   output logic [DATA_W-1:0] o_timer0_count,
   input wire logic i_port_read_source_option,
   input wire logic [DATA_W-1:0] i_port_a_pin,
   input wire logic [DATA_W-1:0] i_port_a_is_input,
   input wire logic [DATA_W-1:0] i_port_b_pin,
   input wire logic [DATA_W-1:0] i_port_b_is_input,
   input wire logic [PORT_C_W-1:0] i_port_c_pin,
   input wire logic [PORT_C_W-1:0] i_port_c_is_input,
   output logic [DATA_W-1:0] o_port_a_latch,
   output logic [DATA_W-1:0] o_port_b_latch,
   output logic [PORT_C_W-1:0] o_port_c_latch
);

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic hit;
   logic rd_hit;
   logic wr_hit;
   logic wr_timer;
   logic wr_pcl;
   logic wr_status;
   logic wr_pointer;
   logic wr_port_a;
   logic wr_port_b;
   logic wr_port_c;
   logic indirect_rd_q;
   logic [DATA_W-1:0] timer_q;
   logic [PC_W-1:0] pc_q;
   logic [DATA_W-1:0] status_q;
   logic [DATA_W-1:0] pointer_q;
   logic [DATA_W-1:0] latch_a_q;
   logic [DATA_W-1:0] latch_b_q;
   logic [PORT_C_W-1:0] latch_c_q;

   // bank bits play no part in this decode
   assign hit = (i_sfr_req.addr <= SFR_BANK_LOW_LAST);
   assign rd_hit = i_sfr_req.rd & hit;
   assign wr_hit = i_sfr_req.wr & hit;
   assign wr_timer = wr_hit & (i_sfr_req.addr == ADDR_TIMER0_COUNT);
   assign wr_pcl = wr_hit & (i_sfr_req.addr == ADDR_PROGRAM_COUNTER_LOW);
   assign wr_status = wr_hit & (i_sfr_req.addr == ADDR_STATUS_FLAGS);
   assign wr_pointer = wr_hit & (i_sfr_req.addr == ADDR_INDIRECT_POINTER);
   assign wr_port_a = wr_hit & (i_sfr_req.addr == ADDR_PORT_A_DATA);
   assign wr_port_b = wr_hit & (i_sfr_req.addr == ADDR_PORT_B_DATA);
   assign wr_port_c = wr_hit & (i_sfr_req.addr == ADDR_PORT_C_DATA);

   // ---------------------------------------------------------------
   // indirect access redirection
   // ---------------------------------------------------------------
   logic ind_access;

   assign ind_access = hit & (i_sfr_req.addr == ADDR_INDIRECT_ACCESS_PORT);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_req <= '0;
      end else begin
         o_mem_req.rd <= ind_access & i_sfr_req.rd;
         o_mem_req.wr <= ind_access & i_sfr_req.wr;
         o_mem_req.addr <= {status_q[ST_BANK_HI:ST_BANK_LO], pointer_q[DADDR_W-1:0]};
         o_mem_req.wdata <= i_sfr_req.wdata;
      end
   end

   // ---------------------------------------------------------------
   // timer0 count and clock selection
   // ---------------------------------------------------------------
   logic ext_pin_q;
   logic ext_rise;
   logic timer_tick;

   assign ext_rise = i_timer0_ext_clock_pin & ~ext_pin_q;
   // mode selects internal instruction clock or external source; config picks pin or low oscillator
   assign timer_tick = !i_timer0_mode_setting ? i_inst_tick :
                       (i_cfg_timer0_low_osc ? i_lfosc_tick : ext_rise);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_pin_q <= 1'b0;
      end else begin
         ext_pin_q <= i_timer0_ext_clock_pin;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_q <= TIMER0_RESET;
      end else if (wr_timer) begin
         timer_q <= i_sfr_req.wdata;
      end else if (timer_tick) begin
         timer_q <= timer_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------
   logic long_op;
   logic [PC_W-1:0] pc_next_seq;

   assign long_op = i_long_jump_instr | i_long_call_instr;
   assign pc_next_seq = pc_q + PC_STEP;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_q <= PC_RESET;
      end else if (long_op) begin
         pc_q <= i_instr_target;
      end else if (wr_pcl) begin
         pc_q <= {i_pc_high_buffer, i_sfr_req.wdata};
      end else if (i_instr_done) begin
         pc_q <= pc_next_seq;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_stack_push <= 1'b0;
         o_stack_data <= PC_RESET;
      end else begin
         o_stack_push <= i_long_call_instr;
         o_stack_data <= pc_next_seq;
      end
   end

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= STATUS_RESET;
      end else begin
         if (wr_status) begin
            status_q <= i_sfr_req.wdata;
         end
         if (i_alu_flags.c_we) begin
            status_q[ST_CARRY] <= i_alu_flags.sub ? ~i_alu_flags.carry : i_alu_flags.carry;
         end
         if (i_alu_flags.dc_we) begin
            status_q[ST_HALF_CARRY] <= i_alu_flags.sub ? ~i_alu_flags.half_carry : i_alu_flags.half_carry;
         end
         if (i_alu_flags.z_we) begin
            status_q[ST_ZERO] <= (i_alu_flags.result == 8'h00);
         end
         if (i_clrwdt_instr) begin
            status_q[ST_POWER_DOWN] <= 1'b1;
         end else if (i_sleep_instr) begin
            status_q[ST_POWER_DOWN] <= 1'b0;
         end
         if (i_wdt_timeout) begin
            status_q[ST_TIMEOUT] <= 1'b0;
         end else if (i_clrwdt_instr | i_sleep_instr) begin
            status_q[ST_TIMEOUT] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // indirect pointer
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pointer_q <= POINTER_RESET;
      end else if (wr_pointer) begin
         pointer_q <= i_sfr_req.wdata;
      end
   end

   // ---------------------------------------------------------------
   // port data latches
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_a_q <= PORT_LATCH_RESET;
         latch_b_q <= PORT_LATCH_RESET;
         latch_c_q <= PORT_LATCH_RESET[PORT_C_W-1:0];
      end else begin
         if (wr_port_a) begin
            latch_a_q <= i_sfr_req.wdata;
         end
         if (wr_port_b) begin
            latch_b_q <= i_sfr_req.wdata;
         end
         if (wr_port_c) begin
            latch_c_q <= i_sfr_req.wdata[PORT_C_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // port read source
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] port_a_view;
   logic [DATA_W-1:0] port_b_view;
   logic [PORT_C_W-1:0] port_c_view;

   // inputs always show the pin; outputs show pin or latch per option
   assign port_a_view = (i_port_a_is_input & i_port_a_pin) |
                        (~i_port_a_is_input & (i_port_read_source_option ? latch_a_q : i_port_a_pin));
   assign port_b_view = (i_port_b_is_input & i_port_b_pin) |
                        (~i_port_b_is_input & (i_port_read_source_option ? latch_b_q : i_port_b_pin));
   assign port_c_view = (i_port_c_is_input & i_port_c_pin) |
                        (~i_port_c_is_input & (i_port_read_source_option ? latch_c_q : i_port_c_pin));

   // ---------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      unique case (i_sfr_req.addr)
         ADDR_TIMER0_COUNT: rd_mux = timer_q;
         ADDR_PROGRAM_COUNTER_LOW: rd_mux = pc_q[DATA_W-1:0];
         ADDR_STATUS_FLAGS: rd_mux = status_q;
         ADDR_INDIRECT_POINTER: rd_mux = pointer_q;
         ADDR_PORT_A_DATA: rd_mux = port_a_view;
         ADDR_PORT_B_DATA: rd_mux = port_b_view;
         ADDR_PORT_C_DATA: rd_mux = {6'h00, port_c_view};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         indirect_rd_q <= 1'b0;
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         indirect_rd_q <= o_mem_req.rd;
         if (o_mem_req.rd) begin
            o_rdata <= i_mem_rdata;
            o_rvalid <= 1'b1;
         end else begin
            o_rdata <= rd_mux;
            o_rvalid <= rd_hit & ~ind_access;
         end
      end
   end

   // ---------------------------------------------------------------
   // state outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pc <= PC_RESET;
         o_status_flags <= STATUS_RESET;
         o_bank_select <= STATUS_RESET[ST_BANK_HI:ST_BANK_LO];
         o_indirect_pointer <= POINTER_RESET;
         o_timer0_count <= TIMER0_RESET;
         o_port_a_latch <= PORT_LATCH_RESET;
         o_port_b_latch <= PORT_LATCH_RESET;
         o_port_c_latch <= PORT_LATCH_RESET[PORT_C_W-1:0];
      end else begin
         o_pc <= pc_q;
         o_status_flags <= status_q;
         o_bank_select <= status_q[ST_BANK_HI:ST_BANK_LO];
         o_indirect_pointer <= pointer_q;
         o_timer0_count <= timer_q;
         o_port_a_latch <= latch_a_q;
         o_port_b_latch <= latch_b_q;
         o_port_c_latch <= latch_c_q;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_indirect_redirect: assert property (
      (i_sfr_req.rd && i_sfr_req.addr == ADDR_INDIRECT_ACCESS_PORT)
      |=> (o_mem_req.rd && o_mem_req.addr == {$past(status_q[ST_BANK_HI:ST_BANK_LO]), $past(pointer_q[6:0])})
      ##1 (o_rvalid && o_rdata == $past(i_mem_rdata)))
      else $error("indirect read not redirected");

   a_timer_read_live: assert property (
      (i_sfr_req.rd && i_sfr_req.addr == ADDR_TIMER0_COUNT) |=> (o_rvalid && o_rdata == $past(timer_q)))
      else $error("timer0 read not live count");

   a_timer_write_load: assert property (
      (i_sfr_req.wr && i_sfr_req.addr == ADDR_TIMER0_COUNT) |=> ##1 (o_timer0_count == $past(i_sfr_req.wdata, 2)))
      else $error("timer0 write not loaded");

   a_pc_advance: assert property (
      (i_instr_done && !long_op && !wr_pcl) |=> (pc_q == $past(pc_q) + PC_STEP))
      else $error("pc did not advance by one");

   a_pcl_write_jump: assert property (
      (wr_pcl && !long_op) |=> (pc_q == {$past(i_pc_high_buffer), $past(i_sfr_req.wdata)}))
      else $error("pc low write target wrong");

   a_long_call_push: assert property (
      i_long_call_instr |=> (o_stack_push && o_stack_data == $past(pc_q) + PC_STEP && pc_q == $past(i_instr_target)))
      else $error("long call push or jump wrong");

   a_zero_flag: assert property (
      (i_alu_flags.z_we) |=> (status_q[ST_ZERO] == ($past(i_alu_flags.result) == 8'h00)))
      else $error("zero flag wrong");

   a_sleep_power_down: assert property (
      (i_sleep_instr && !i_clrwdt_instr) |=> !status_q[ST_POWER_DOWN] ##1 !o_status_flags[ST_POWER_DOWN])
      else $error("power-down flag not cleared by sleep");

   a_timeout_clear: assert property (
      i_wdt_timeout |=> !status_q[ST_TIMEOUT])
      else $error("timeout flag not cleared");

   a_port_c_upper: assert property (
      (i_sfr_req.rd && i_sfr_req.addr == ADDR_PORT_C_DATA) |=> (o_rdata[7:2] == 6'h00))
      else $error("port c upper bits not zero");

endmodule : core_sfr_bank_low

/* File: tb/data_mem_model.sv */
// data memory model answering the redirected indirect accesses of the register bank
`timescale 1ns/1ps

module data_mem_model
   import core_sfr_bank_low_pkg::*;
(
   input wire logic i_ref_clk,
   input wire mem_req_s i_mem_req,
   output logic [DATA_W-1:0] o_mem_rdata
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mem_q [2**MEM_ADDR_W];
   logic [DATA_W-1:0] junk_q = 8'h5a;

   always @(posedge i_ref_clk) begin
      junk_q <= junk_q + 8'h3b;
      if (i_mem_req.wr === 1'b1) begin
         mem_q[i_mem_req.addr] <= i_mem_req.wdata;
      end
   end

   // answer only while read is asked, otherwise a changing pattern
   assign o_mem_rdata = (i_mem_req.rd === 1'b1) ? mem_q[i_mem_req.addr] : junk_q;
endmodule : data_mem_model

/* File: tb/core_sfr_bank_low_bench.sv */
// self-checking bench for the low special-function register bank
`timescale 1ns/1ps

module core_sfr_bank_low_bench
   import core_sfr_bank_low_pkg::*;
   ;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [3:0] PAT_I = 4'h7;
   localparam logic [3:0] PAT_L = 4'h3;
   localparam logic [3:0] PAT_P = 4'h1;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   sfr_req_s req = '0;
   alu_flags_s alu = '0;
   mem_req_s mreq;
   logic [7:0] rdata, mem_rdata, st, ptr, tcnt, a_latch, b_latch, got, exp_st;
   logic [7:0] a_pin = '0, a_in = '0, b_pin = '0, b_in = '0;
   logic [1:0] c_pin = '0, c_in = '0, c_latch, bank;
   logic inst = 1'b0, ext_pin = 1'b0, lf = 1'b0, mode = 1'b0, cfg_lf = 1'b0, opt = 1'b0;
   logic done = 1'b0, ljmp = 1'b0, long_call_instr = 1'b0, clr = 1'b0, slp = 1'b0, tmo = 1'b0;
   logic rvalid, push;
   logic [10:0] pc, sdata, push_data, target = '0;
   logic [2:0] hbuf = '0;
   int fail_count = 0;
   int comparisons = 0;
   int pushes = 0;

   always #5 ref_clk = ~ref_clk;

   // ---------------------------------------------------------------
   // design and memory
   // ---------------------------------------------------------------
   core_sfr_bank_low core_sfr_bank_low_inst (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_sfr_req(req),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_mem_req(mreq), .i_mem_rdata(mem_rdata), .i_inst_tick(inst),
      .i_timer0_ext_clock_pin(ext_pin), .i_lfosc_tick(lf), .i_timer0_mode_setting(mode),
      .i_cfg_timer0_low_osc(cfg_lf), .i_instr_done(done), .i_long_jump_instr(ljmp),
      .i_long_call_instr(long_call_instr), .i_instr_target(target), .i_pc_high_buffer(hbuf), .o_pc(pc),
      .o_stack_push(push), .o_stack_data(sdata), .i_alu_flags(alu), .i_clrwdt_instr(clr),
      .i_sleep_instr(slp), .i_wdt_timeout(tmo), .o_status_flags(st), .o_bank_select(bank),
      .o_indirect_pointer(ptr), .o_timer0_count(tcnt), .i_port_read_source_option(opt),
      .i_port_a_pin(a_pin), .i_port_a_is_input(a_in), .i_port_b_pin(b_pin), .i_port_b_is_input(b_in),
      .i_port_c_pin(c_pin), .i_port_c_is_input(c_in), .o_port_a_latch(a_latch),
      .o_port_b_latch(b_latch), .o_port_c_latch(c_latch));

   data_mem_model data_mem_model_inst (.i_ref_clk(ref_clk), .i_mem_req(mreq), .o_mem_rdata(mem_rdata));

   always @(negedge ref_clk) begin
      if (push === 1'b1) begin
         pushes++;
         push_data = sdata;
      end
   end

   // ---------------------------------------------------------------
   // tasks and expectations
   // ---------------------------------------------------------------
   task automatic conclude();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         fail_count++;
      end
   endtask : chk

   task automatic bus_wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge ref_clk);
      req <= '0;
   endtask : bus_wr

   task automatic bus_rd(input logic [6:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge ref_clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      req <= '0;
      for (int n = 0; n < 4; n++) begin
         #1;
         if (rvalid === 1'b1) begin
            d = rdata;
            break;
         end
         @(posedge ref_clk);
      end
   endtask : bus_rd

   task automatic pcev(input logic d, input logic j, input logic c, input logic [10:0] t);
      @(posedge ref_clk);
      {done, ljmp, long_call_instr, target} <= {d, j, c, t};
      @(posedge ref_clk);
      {done, ljmp, long_call_instr} <= 3'b000;
      @(posedge ref_clk);
      #1;
   endtask : pcev

   function automatic logic [7:0] next_status(input logic [7:0] s, input alu_flags_s a, input logic [2:0] ev);
      logic [7:0] r;
      r = s;
      if (a.c_we) r[0] = a.carry ^ a.sub;
      if (a.dc_we) r[1] = a.half_carry ^ a.sub;
      if (a.z_we) r[2] = (a.result == 8'h00);
      if (ev[2]) r[3] = 1'b1;
      else if (ev[1]) r[3] = 1'b0;
      if (ev[0]) r[4] = 1'b0;
      else if (ev[2] | ev[1]) r[4] = 1'b1;
      return r;
   endfunction : next_status

   function automatic logic [7:0] port_exp(input logic [7:0] pin, input logic [7:0] inp, input logic [7:0] lat,
                                           input logic o);
      return (pin & (inp | ~{8{o}})) | (lat & ~inp & {8{o}});
   endfunction : port_exp

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin : watchdog
      #100us;
      fail_count++;
      conclude();
   end

   initial begin : main
      logic [7:0] v, w, e;
      logic [7:0] vals [4];
      logic [6:0] q;
      logic [2:0] hb;
      logic [10:0] p;
      alu_flags_s a;
      int k;
      void'($urandom(89));
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(st, 8'h18);
      chk(pc, 11'h000);
      v = 8'($urandom);
      bus_wr(7'h03, v);
      bus_rd(7'h03, got);
      chk(got, v);
      chk(bank, v[7:6]);
      bus_wr(7'h03, 8'hc0);
      v = 8'($urandom);
      bus_wr(7'h04, v);
      bus_rd(7'h04, got);
      chk(got, v);
      chk(ptr, v);
      q = 7'($urandom);
      for (int b = 0; b < 4; b++) begin
         vals[b] = 8'($urandom);
         bus_wr(7'h03, {2'(b), 6'h00});
         bus_wr(7'h04, {1'(b), q});
         bus_wr(7'h00, vals[b]);
      end
      for (int b = 3; b >= 0; b--) begin
         bus_wr(7'h03, {2'(b), 6'h00});
         bus_wr(7'h04, {1'(b + 1), q});
         bus_rd(7'h00, got);
         chk(got, vals[b]);
      end
      for (int s = 0; s < 3; s++) begin
         @(posedge ref_clk);
         {mode, cfg_lf} <= {s != 0, s == 1};
         v = 8'($urandom);
         bus_wr(7'h01, v);
         bus_rd(7'h01, got);
         chk(got, v);
         for (int n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            {inst, lf, ext_pin} <= {PAT_I[n % 4], PAT_L[n % 4], PAT_P[n % 4]};
         end
         @(posedge ref_clk);
         {inst, lf, ext_pin} <= 3'b000;
         bus_rd(7'h01, got);
         chk(got, 8'(v + 8'(5 * (3 - s))));
         chk(tcnt, 8'(v + 8'(5 * (3 - s))));
      end
      hb = 3'($urandom);
      w = 8'($urandom);
      @(posedge ref_clk);
      hbuf <= hb;
      bus_wr(7'h02, w);
      @(posedge ref_clk);
      #1;
      chk(pc, {hb, w});
      k = 1 + $urandom % 5;
      repeat (k) pcev(1'b1, 1'b0, 1'b0, 11'h000);
      chk(pc, 11'({hb, w} + 11'(k)));
      bus_rd(7'h02, got);
      chk(got, 8'(w + 8'(k)));
      p = 11'($urandom);
      pcev(1'b1, 1'b1, 1'b0, p);
      chk(pc, p);
      pcev(1'b0, 1'b0, 1'b1, 11'h7ff - p);
      chk(pc, 11'h7ff - p);
      chk(16'(pushes), 16'd1);
      chk(push_data, 11'(p + 11'h001));
      exp_st = 8'($urandom);
      bus_wr(7'h03, exp_st);
      for (int n = 0; n < 16; n++) begin
         a = 14'($urandom);
         if (n < 3) a.result = 8'h00;
         @(posedge ref_clk);
         alu <= a;
         {clr, slp, tmo} <= 3'(n);
         @(posedge ref_clk);
         alu <= '0;
         {clr, slp, tmo} <= 3'b000;
         @(posedge ref_clk);
         #1;
         exp_st = next_status(exp_st, a, 3'(n));
         chk(st, exp_st);
      end
      for (int o = 0; o < 2; o++) begin
         v = 8'($urandom);
         w = 8'($urandom);
         e = 8'($urandom);
         bus_wr(7'h05, v);
         bus_wr(7'h06, w);
         bus_wr(7'h07, e);
         @(posedge ref_clk);
         {opt, a_pin, a_in, b_pin, b_in, c_pin, c_in} <= {1'(o), 32'($urandom), 4'($urandom)};
         @(posedge ref_clk);
         #1;
         chk(a_latch, v);
         chk(b_latch, w);
         chk(c_latch, e[1:0]);
         bus_rd(7'h05, got);
         chk(got, port_exp(a_pin, a_in, v, opt));
         bus_rd(7'h06, got);
         chk(got, port_exp(b_pin, b_in, w, opt));
         bus_rd(7'h07, got);
         chk(got, port_exp({6'h00, c_pin}, {6'h00, c_in}, {6'h00, e[1:0]}, opt));
      end
      // reset again in mid-run and look at the values after release
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(st, 8'h18);
      chk(pc, 11'h000);
      chk(ptr, 8'h00);
      conclude();
   end
endmodule : core_sfr_bank_low_bench
